// File: dv/flc_flash_model.sv
// Behavioural model of the parallel flash device that the host drives.
`timescale 1ns/1ps
module flc_flash_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [15:0] MFG_CODE = 16'h0011, // Arbitrary value.
  parameter logic [15:0] DEV_CODE = 16'h0022 // Arbitrary value.
) (
  // Control pins, active low.
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_powerdown_n,
  input wire logic flash_wp_n,
  // Address and data in both directions.
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_i,
  // Open-drain ready/busy, pulled up outside.
  output wire flash_ready_busy_n
);
  logic [15:0] arr [16];
  logic [31:0] lk = 32'h0000_0000;
  logic [15:0] otp = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [7:0] setup = 8'h00;
  logic [7:0] st_lat = 8'h00;
  logic [1:0] mode = 2'h0;
  logic perm = 1'b0;
  logic prot = 1'b0;
  logic susp = 1'b0;
  int cnt = 0;
  // Bus cycles decoded from the strobes; reset-powerdown masks both.
  wire wr = flash_reset_powerdown_n && !flash_ce_n && !flash_we_n && flash_oe_n;
  wire rd = flash_reset_powerdown_n && !flash_ce_n && !flash_oe_n && flash_we_n;
  wire busy = cnt != 0;
  wire [7:0] stat = {!busy, susp, 1'b0, prot, 2'b00, prot, 1'b0};
  // Low only while an algorithm runs unsuspended.
  assign flash_ready_busy_n = busy && !susp ? 1'b0 : 1'bz;
  // Boot block 0 is also held by write-protect.
  function automatic logic held(input logic [4:0] b);
    return lk[b] || (b == 5'h00 && !flash_wp_n);
  endfunction
  // Released lines show the inverse of the last value, so nothing stale passes.
  always_comb
  begin
    case (rd ? mode : 2'h3)
      2'h0: flash_dq_i = arr[{flash_addr[16], flash_addr[2:0]}];
      2'h1: flash_dq_i = flash_addr[1:0] == 2'h0 ? MFG_CODE : flash_addr[1:0] == 2'h1 ? DEV_CODE
        : {15'h0000, flash_addr[0] ? perm : lk[flash_addr[20:16]]};
      2'h2: flash_dq_i = {8'h00, st_lat};
      default: flash_dq_i = ~last;
    endcase
  end
  // Remember what was last shown, and latch status at the start of a read.
  always @(flash_dq_i) if (rd) last = flash_dq_i;
  always @(posedge rd) st_lat = stat;
  // The algorithm time runs down only while not suspended.
  always #10 if (cnt > 0 && !susp) cnt -= 10;
  // Reset mode aborts and returns to array reads; lock bits are kept.
  always @(negedge flash_reset_powerdown_n)
  begin
    mode = 2'h0;
    setup = 8'h00;
    cnt = 0;
    susp = 1'b0;
  end
  initial for (int i = 0; i < 16; i++) arr[i] = 16'hFFFF;
  // Commands are latched where the first of the two strobes rises.
  always @(negedge wr)
  begin
    if (setup == 8'h00)
    begin
      case (flash_dq_o[7:0])
        8'hFF: mode = busy && !susp ? mode : 2'h0;
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h50: prot = 1'b0;
        8'hB0: susp = busy;
        8'hD0: susp = 1'b0;
        default: setup = flash_dq_o[7:0];
      endcase
    end
    else
    begin
      case (setup)
        8'h20, 8'h30: if (flash_dq_o[7:0] == 8'hD0) for (int i = 0; i < 16; i++)
          if (!held({4'h0, i[3]}) && (setup == 8'h30 || i[3] == flash_addr[16]))
            arr[i] = 16'hFFFF;
        8'h40, 8'h10: if (!held(flash_addr[20:16]))
          arr[{flash_addr[16], flash_addr[2:0]}] &= flash_dq_o;
        8'hC0: otp = flash_dq_o;
        8'h60: if (flash_dq_o[7:0] == 8'hF1) perm = 1'b1;
          else if (perm) prot = 1'b1;
          else if (flash_dq_o[7:0] == 8'h01) lk[flash_addr[20:16]] = 1'b1;
          else lk = 32'h0000_0000;
        default: ;
      endcase
      prot |= (setup == 8'h40 || setup == 8'h20) && held(flash_addr[20:16]);
      cnt = BUSY_NS;
      setup = 8'h00;
      mode = 2'h2;
    end
  end
endmodule // flc_flash_model

// File: dv/flc_host_chk.sv
// Checker of the flash host controller ports.
`timescale 1ns/1ps
module flc_host_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // User side.
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic cmd_ready,
  input wire logic cmd_refused,
  input wire logic rsp_valid,
  input wire logic flash_busy,
  input wire logic suspended,
  input wire logic perm_locked,
  input wire logic wp_level,
  // Flash pins.
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_ce_n,
  input wire logic flash_reset_powerdown_n,
  input wire logic flash_wp_n,
  input wire logic [flc_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A request is taken where valid meets ready.
  wire take = cmd_valid && cmd_ready;
  chk_no_fight:
    assert property (flash_oe_n || flash_we_n) else $error("oe and we low together");
  chk_read_bus:
    assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe) else $error("bad read");
  chk_write_bus:
    assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe) else $error("bad write");
  chk_write_hold:
    assert property ($rose(flash_we_n) |-> $stable(flash_dq_o) && flash_dq_oe)
    else $error("data moved at latch edge");
  chk_reset_quiet:
    assert property (!flash_reset_powerdown_n |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("strobe during reset");
  chk_array_refuse:
    assert property (take && cmd_op == 4'h1 && flash_busy && !suspended |=> cmd_refused)
    else $error("array read not refused");
  chk_lock_refuse:
    assert property (take && perm_locked && (cmd_op == 4'hA || cmd_op == 4'hB) |=> cmd_refused)
    else $error("lock change not refused");
  chk_perm_sticky:
    assert property (perm_locked |=> perm_locked) else $error("permanent lock cleared");
  chk_read_answer:
    assert property (take && cmd_op == 4'h0 |-> ##[13:15] rsp_valid) else $error("no read data");
  chk_wp_follow:
    assert property ($past(rst_n) |-> flash_wp_n == $past(wp_level)) else $error("wp lags");
endmodule // flc_host_chk

// File: dv/test_flash_command_decoder.sv
// Self-checking testbench of the flash host controller against a flash device model.
`timescale 1ns/1ps
module test_flash_command_decoder;
  localparam logic [15:0] MFG = 16'h005A; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h00C3; // Arbitrary value.
  // Stimulus, all given values at time zero.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic wp_level = 1'b1;
  logic [3:0] cmd_op = 4'h0;
  logic [20:0] cmd_addr = 21'h0_0000;
  logic [15:0] cmd_data = 16'h0000;
  // Design outputs and flash pins.
  logic cmd_ready, cmd_refused, rsp_valid, flash_busy, suspended, perm_locked, r;
  logic [1:0] read_mode;
  logic [15:0] rsp_data, flash_dq_o, flash_dq_i;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_powerdown_n, flash_wp_n, flash_dq_oe;
  logic [20:0] flash_addr;
  tri1 flash_ready_busy_n;
  int fail_count = 0;
  int comparisons = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  // Controller and device.
  flc_host flc_host_i (
    .clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .cmd_refused,
    .rsp_valid, .rsp_data, .read_mode, .flash_busy, .suspended, .perm_locked, .wp_level,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_powerdown_n, .flash_wp_n, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ready_busy_n
  );
  flc_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) flc_flash_model_i (
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_powerdown_n, .flash_wp_n, .flash_addr,
    .flash_dq_o, .flash_dq_i, .flash_ready_busy_n
  );
  // Counts, verdict and end of run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Compare one value with its expectation.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that runs out counts as a mismatch and ends the run.
  task automatic expire();
    fail_count++;
    $display("CHECK FAILED at %0t: wait expired", $time);
    complete_run();
  endtask
  // Wait at falling edges for ready and, if asked, for the device to go idle.
  task automatic wt(input logic idle);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 || (idle && flash_busy !== 1'b0))
    begin
      @(negedge clk);
      n++;
      if (n > 2000)
        expire();
    end
  endtask
  // Hand one request over; the rising edge in between takes it.
  task automatic go(input logic [3:0] o, input logic [20:0] a, input logic [15:0] d);
    wt(1'b0);
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    r = cmd_refused;
    // Let an edge pass with valid low before any next request.
    @(negedge clk);
  endtask
  // Read one word and compare the answer.
  task automatic rd(input logic [20:0] a, input logic [15:0] e);
    int n;
    n = 0;
    go(4'h0, a, 16'h0000);
    while (rsp_valid !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 40)
        expire();
    end
    check(rsp_data, e);
  endtask
  // Writes land, status shows busy then ready, array mode returns the data.
  task automatic t_write();
    wt(1'b1);
    check({14'h0000, read_mode}, 16'h0000);
    rd(21'h0_0005, 16'hFFFF);
    go(4'h7, 21'h0_0005, 16'h1234);
    rd(21'h0_0005, 16'h0000);
    wt(1'b1);
    rd(21'h0_0005, 16'h0080);
    go(4'h7, 21'h1_0005, 16'h00FF);
    wt(1'b1);
    go(4'h1, 21'h0_0000, 16'h0000);
    rd(21'h0_0005, 16'h1234);
    go(4'h3, 21'h0_0000, 16'h0000);
    check({14'h0000, read_mode}, 16'h0002);
    rd(21'h0_0005, 16'h0080);
    $display("write test done");
  endtask
  // Block erase is refused an array read until suspended, then resumes.
  task automatic t_erase();
    go(4'h5, 21'h1_0000, 16'h0000);
    go(4'h1, 21'h0_0000, 16'h0000);
    check({15'h0000, r}, 16'h0001);
    go(4'h8, 21'h0_0000, 16'h0000);
    wt(1'b1);
    check({15'h0000, suspended}, 16'h0001);
    go(4'h1, 21'h0_0000, 16'h0000);
    check({15'h0000, r}, 16'h0000);
    rd(21'h0_0005, 16'h1234);
    go(4'h9, 21'h0_0000, 16'h0000);
    wt(1'b0);
    check({15'h0000, flash_busy}, 16'h0001);
    wt(1'b1);
    go(4'h1, 21'h0_0000, 16'h0000);
    rd(21'h1_0005, 16'hFFFF);
    go(4'h6, 21'h0_0000, 16'h0000);
    wt(1'b1);
    go(4'h1, 21'h0_0000, 16'h0000);
    rd(21'h0_0005, 16'hFFFF);
    $display("erase test done");
  endtask
  // Identifier reads, block locks, status clear and write-protect.
  task automatic t_lock();
    go(4'h2, 21'h0_0000, 16'h0000);
    rd(21'h0_0000, MFG);
    rd(21'h0_0001, DEV);
    rd(21'h0_0003, 16'h0000);
    go(4'hA, 21'h1_0000, 16'h0000);
    wt(1'b1);
    go(4'h7, 21'h1_0002, 16'h0000);
    wt(1'b1);
    rd(21'h0_0000, 16'h0092);
    go(4'h4, 21'h0_0000, 16'h0000);
    rd(21'h0_0000, 16'h0080);
    go(4'hB, 21'h0_0000, 16'h0000);
    wt(1'b1);
    go(4'h2, 21'h0_0000, 16'h0000);
    rd(21'h1_0002, 16'h0000);
    wp_level = 1'b0;
    go(4'h7, 21'h0_0003, 16'h0000);
    wt(1'b1);
    rd(21'h0_0000, 16'h0092);
    go(4'h4, 21'h0_0000, 16'h0000);
    go(4'h7, 21'h1_0003, 16'h0000);
    wt(1'b1);
    rd(21'h0_0000, 16'h0080);
    wp_level = 1'b1;
    go(4'h7, 21'h0_0003, 16'h0000);
    wt(1'b1);
    rd(21'h0_0000, 16'h0080);
    $display("lock test done");
  endtask
  // One-time block, a reserved code, reset pulse, then the permanent lock.
  task automatic t_perm();
    go(4'hD, 21'h0_0081, 16'h5AA5);
    wt(1'b1);
    check(flc_flash_model_i.otp, 16'h5AA5);
    go(4'hF, 21'h0_0000, 16'h0000);
    check({15'h0000, r}, 16'h0001);
    go(4'hE, 21'h0_0000, 16'h0000);
    wt(1'b1);
    check({14'h0000, read_mode}, 16'h0000);
    rd(21'h0_0003, 16'h0000);
    go(4'hC, 21'h0_0000, 16'h0000);
    wt(1'b1);
    check({15'h0000, perm_locked}, 16'h0001);
    go(4'hA, 21'h1_0000, 16'h0000);
    check({15'h0000, r}, 16'h0001);
    go(4'hB, 21'h0_0000, 16'h0000);
    check({15'h0000, r}, 16'h0001);
    go(4'h2, 21'h0_0000, 16'h0000);
    rd(21'h0_0003, 16'h0001);
    $display("permanent lock test done");
  endtask
  // Reset for two cycles, then the scenarios in order.
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_write();
    t_erase();
    t_lock();
    t_perm();
    complete_run();
  end
endmodule // test_flash_command_decoder
bind flc_host flc_host_chk flc_host_chk_i (
  .clk, .rst_n, .cmd_valid, .cmd_op, .cmd_ready, .cmd_refused, .rsp_valid, .flash_busy,
  .suspended, .perm_locked, .wp_level, .flash_oe_n, .flash_we_n, .flash_ce_n,
  .flash_reset_powerdown_n, .flash_wp_n, .flash_dq_o, .flash_dq_oe
);

// File: src/flc_host.sv
// Host controller that drives an asynchronous parallel NOR flash through its pins.
// Contract
// R1 - Device reads array after reset or after an FFH write.
// R2 - A read mode stays in force until another command is written.
// R3 - Read array is ignored while an operation runs unsuspended.
// R4 - After 90H, reads at identifier addresses return codes and lock states.
// R5 - After 70H reads return status; 50H clears error bits.
// R6 - Block erase is 20H then D0H at an address inside the block.
// R7 - Chip erase is 30H then D0H at any address.
// R8 - Word/byte write is 40H or 10H, then address and data.
// R9 - Second write is captured on first rising edge of write or select.
// R10 - OTP program is C0H, then address in that block and data.
// R11 - Suspend is one write; resume is one D0H write.
// R12 - Lock setup 60H, then 01H block lock, D0H clear all, F1H permanent.
// R13 - With permanent lock set, block lock set and clear are refused.
// R14 - The permanent lock bit can never be cleared.
// R15 - Write-protect low locks boot blocks regardless of lock bits.
// R16 - Parameter and main blocks follow only their lock bits.
// R17 - Ready/busy drives low while an algorithm runs.
// R18 - Ready/busy floats when idle, suspended or in reset.
// R19 - Output enable and write enable are never low together.
// R20 - At program supply lockout, reads work but memory is unchanged.
// R21 - Only defined command codes are ever written.
// R22 - After an accepted erase or write sequence, reads return status.
// R23 - Status is captured on the read strobe; a high pulse precedes the next.
// R24 - Select low, output enable low, write enable high is a read.
// R25 - Reset-powerdown low floats outputs and ignores other controls.
// R26 - Select low, write enable low, output enable high is a write.
`timescale 1ns/1ps
module flc_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // User command port.
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [flc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [flc_pkg::DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic cmd_refused,
  // User read answer and tracked device state.
  output logic rsp_valid,
  output logic [flc_pkg::DATA_W-1:0] rsp_data,
  output logic [1:0] read_mode,
  output logic flash_busy,
  output logic suspended,
  output logic perm_locked,
  // Boot-block write-protect level requested by software.
  input wire logic wp_level,
  // Flash pins.
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_powerdown_n,
  output logic flash_wp_n,
  output logic [flc_pkg::ADDR_W-1:0] flash_addr,
  output logic [flc_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [flc_pkg::DATA_W-1:0] flash_dq_i,
  input wire logic flash_ready_busy_n
);

  flc_pkg::flc_state_e state_r, state_nxt;
  flc_pkg::flc_mode_e mode_r, mode_nxt;
  logic [7:0] timer_r, timer_nxt;
  logic second_r, second_nxt;
  logic [flc_pkg::DATA_W-1:0] second_data_r, second_data_nxt;
  logic suspended_r, suspended_nxt;
  logic perm_locked_r, perm_locked_nxt;
  logic ce_n_r, ce_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic we_n_r, we_n_nxt;
  logic pd_n_r, pd_n_nxt;
  logic wp_n_r, wp_n_nxt;
  logic [flc_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [flc_pkg::DATA_W-1:0] dq_r, dq_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [flc_pkg::DATA_W-1:0] rsp_data_r, rsp_data_nxt;
  logic refused_r, refused_nxt;
  logic [flc_pkg::DATA_W:0] pins_sync;
  logic busy_s;
  logic take;
  logic refuse;
  logic two_cycle;
  logic [7:0] code1;
  logic [flc_pkg::DATA_W-1:0] data2;

  // Ready/busy and data lines come from the flash clock-free domain.
  flc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({flash_ready_busy_n, flash_dq_i}),
    .pin_sync(pins_sync)
  );

  // An open-drain busy line reads low only while an algorithm runs, high when floated.
  assign busy_s = ~pins_sync[flc_pkg::DATA_W]; // R17 R18

  // Command codes per operation: only defined codes can reach the data lines.
  always_comb
  begin
    code1 = flc_pkg::CMD_READ_ARRAY;
    data2 = cmd_data;
    two_cycle = 1'b0;
    case (cmd_op)
      flc_pkg::OP_READ_ARRAY: code1 = flc_pkg::CMD_READ_ARRAY; // R1 R21
      flc_pkg::OP_READ_ID: code1 = flc_pkg::CMD_READ_ID; // R4
      flc_pkg::OP_READ_STATUS: code1 = flc_pkg::CMD_READ_STATUS; // R5
      flc_pkg::OP_CLEAR_STATUS: code1 = flc_pkg::CMD_CLEAR_STATUS; // R5
      flc_pkg::OP_BLOCK_ERASE:
      begin
        code1 = flc_pkg::CMD_BLOCK_ERASE; // R6
        data2 = {8'h00, flc_pkg::CMD_CONFIRM};
        two_cycle = 1'b1;
      end
      flc_pkg::OP_CHIP_ERASE:
      begin
        code1 = flc_pkg::CMD_CHIP_ERASE; // R7
        data2 = {8'h00, flc_pkg::CMD_CONFIRM};
        two_cycle = 1'b1;
      end
      flc_pkg::OP_WORD_WRITE:
      begin
        code1 = flc_pkg::CMD_WRITE; // R8
        two_cycle = 1'b1;
      end
      flc_pkg::OP_SUSPEND: code1 = flc_pkg::CMD_SUSPEND; // R11
      flc_pkg::OP_RESUME: code1 = flc_pkg::CMD_CONFIRM; // R11
      flc_pkg::OP_SET_BLOCK_LOCK:
      begin
        code1 = flc_pkg::CMD_LOCK_SETUP; // R12
        data2 = {8'h00, flc_pkg::CMD_LOCK_BLOCK};
        two_cycle = 1'b1;
      end
      flc_pkg::OP_CLEAR_LOCKS:
      begin
        code1 = flc_pkg::CMD_LOCK_SETUP; // R12
        data2 = {8'h00, flc_pkg::CMD_CONFIRM};
        two_cycle = 1'b1;
      end
      flc_pkg::OP_SET_PERM_LOCK:
      begin
        code1 = flc_pkg::CMD_LOCK_SETUP; // R12
        data2 = {8'h00, flc_pkg::CMD_LOCK_PERM};
        two_cycle = 1'b1;
      end
      flc_pkg::OP_OTP_PROGRAM:
      begin
        code1 = flc_pkg::CMD_OTP_PROGRAM; // R10
        two_cycle = 1'b1;
      end
      default: code1 = flc_pkg::CMD_READ_ARRAY;
    endcase
  end

  // Refuse what the device would ignore, and codes outside the defined set.
  always_comb
  begin
    refuse = 1'b0;
    if (cmd_op == flc_pkg::OP_READ_ARRAY && busy_s && !suspended_r)
      refuse = 1'b1; // R3
    if ((cmd_op == flc_pkg::OP_SET_BLOCK_LOCK || cmd_op == flc_pkg::OP_CLEAR_LOCKS)
        && perm_locked_r)
      refuse = 1'b1; // R13
    if (cmd_op == 4'hF)
      refuse = 1'b1; // R21
  end

  assign cmd_ready = (state_r == flc_pkg::S_IDLE);
  assign take = cmd_valid && cmd_ready;

  // Bus sequencer: write and read strobes are separate states, so both are never low.
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    timer_nxt = (timer_r != 8'h00) ? timer_r - 8'h01 : 8'h00;
    second_nxt = second_r;
    second_data_nxt = second_data_r;
    suspended_nxt = suspended_r;
    perm_locked_nxt = perm_locked_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    pd_n_nxt = pd_n_r;
    wp_n_nxt = wp_level; // R15 R16
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    dq_oe_nxt = dq_oe_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    refused_nxt = 1'b0;
    case (state_r)
      flc_pkg::S_RESET:
      begin
        pd_n_nxt = 1'b0; // R25
        ce_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        dq_oe_nxt = 1'b0;
        suspended_nxt = 1'b0;
        mode_nxt = flc_pkg::MODE_ARRAY; // R1
        if (timer_r == 8'h00)
        begin
          pd_n_nxt = 1'b1;
          timer_nxt = flc_pkg::WAKE_CYC;
          state_nxt = flc_pkg::S_WAKE;
        end
      end
      flc_pkg::S_WAKE:
        if (timer_r == 8'h00)
          state_nxt = flc_pkg::S_IDLE;
      flc_pkg::S_IDLE:
        if (take && refuse)
          refused_nxt = 1'b1;
        else if (take && cmd_op == flc_pkg::OP_RESET)
        begin
          pd_n_nxt = 1'b0;
          timer_nxt = flc_pkg::PD_LOW_CYC;
          state_nxt = flc_pkg::S_RESET;
        end
        else if (take && cmd_op == flc_pkg::OP_READ)
        begin
          ce_n_nxt = 1'b0; // R24
          oe_n_nxt = 1'b0; // R19
          addr_nxt = cmd_addr;
          timer_nxt = flc_pkg::READ_CYC;
          state_nxt = flc_pkg::S_RD_LOW;
        end
        else if (take)
        begin
          ce_n_nxt = 1'b0; // R26
          we_n_nxt = 1'b0; // R19
          addr_nxt = cmd_addr;
          dq_nxt = {8'h00, code1};
          dq_oe_nxt = 1'b1;
          second_nxt = two_cycle;
          second_data_nxt = data2;
          timer_nxt = flc_pkg::WE_LOW_CYC;
          state_nxt = flc_pkg::S_WR_LOW;
          // Track what later reads return; clear status keeps the mode.
          case (cmd_op)
            flc_pkg::OP_READ_ARRAY: mode_nxt = flc_pkg::MODE_ARRAY; // R1 R2
            flc_pkg::OP_READ_ID: mode_nxt = flc_pkg::MODE_ID; // R2 R4
            flc_pkg::OP_CLEAR_STATUS: mode_nxt = mode_r;
            default: mode_nxt = flc_pkg::MODE_STATUS; // R5 R22
          endcase
          if (cmd_op == flc_pkg::OP_SUSPEND)
            suspended_nxt = 1'b1;
          if (cmd_op == flc_pkg::OP_RESUME)
            suspended_nxt = 1'b0;
          if (cmd_op == flc_pkg::OP_SET_PERM_LOCK)
            perm_locked_nxt = 1'b1; // R14
        end
      flc_pkg::S_WR_LOW:
        if (timer_r == 8'h00)
        begin
          // Both strobes rise together; data and address hold through the high time.
          we_n_nxt = 1'b1; // R9
          ce_n_nxt = 1'b1;
          timer_nxt = flc_pkg::WE_HIGH_CYC;
          state_nxt = flc_pkg::S_WR_HIGH;
        end
      flc_pkg::S_WR_HIGH:
        if (timer_r == 8'h00)
        begin
          if (second_r)
          begin
            second_nxt = 1'b0;
            ce_n_nxt = 1'b0;
            we_n_nxt = 1'b0;
            dq_nxt = second_data_r; // R6 R7 R8 R10 R12
            timer_nxt = flc_pkg::WE_LOW_CYC;
            state_nxt = flc_pkg::S_WR_LOW;
          end
          else
          begin
            dq_oe_nxt = 1'b0;
            state_nxt = flc_pkg::S_IDLE;
          end
        end
      flc_pkg::S_RD_LOW:
        if (timer_r == 8'h00)
        begin
          rsp_data_nxt = pins_sync[flc_pkg::DATA_W-1:0]; // R2 R20
          rsp_valid_nxt = 1'b1;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          timer_nxt = flc_pkg::OE_HIGH_CYC;
          state_nxt = flc_pkg::S_RD_HIGH;
        end
      flc_pkg::S_RD_HIGH:
        if (timer_r == 8'h00)
          state_nxt = flc_pkg::S_IDLE; // R23
      default: state_nxt = flc_pkg::S_IDLE;
    endcase
  end

  // Reset holds the flash in its own reset for the least low time.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= flc_pkg::S_RESET;
      mode_r <= flc_pkg::MODE_ARRAY;
      timer_r <= flc_pkg::PD_LOW_CYC;
      second_r <= 1'b0;
      second_data_r <= 16'h0000;
      suspended_r <= 1'b0;
      perm_locked_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      pd_n_r <= 1'b0;
      wp_n_r <= 1'b0;
      addr_r <= 21'h00_0000;
      dq_r <= 16'h0000;
      dq_oe_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      refused_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      timer_r <= timer_nxt;
      second_r <= second_nxt;
      second_data_r <= second_data_nxt;
      suspended_r <= suspended_nxt;
      perm_locked_r <= perm_locked_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      pd_n_r <= pd_n_nxt;
      wp_n_r <= wp_n_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      refused_r <= refused_nxt;
    end
  end

  // All pin and answer outputs come straight from flops.
  assign flash_ce_n = ce_n_r;
  assign flash_oe_n = oe_n_r;
  assign flash_we_n = we_n_r;
  assign flash_reset_powerdown_n = pd_n_r;
  assign flash_wp_n = wp_n_r;
  assign flash_addr = addr_r;
  assign flash_dq_o = dq_r;
  assign flash_dq_oe = dq_oe_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign cmd_refused = refused_r;
  assign read_mode = mode_r;
  assign flash_busy = busy_s;
  assign suspended = suspended_r;
  assign perm_locked = perm_locked_r;

endmodule // flc_host

// File: src/flc_pkg.sv
// Package: command codes, operations, pin widths and timing counts of the flash host controller.
package flc_pkg;

  // Pin widths of the parallel flash bus.
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;

  // Command codes written on the data lines.
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_PERM = 8'hF1;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'hC0;

  // Timing figures in ns; the clock period is 10 ns.
  localparam int CLK_NS = 10;
  localparam int T_PD_LOW_NS = 100;
  localparam int T_WAKE_NS = 150;
  localparam int T_WE_LOW_NS = 50;
  localparam int T_WE_HIGH_NS = 30;
  localparam int T_READ_ACC_NS = 100;
  localparam int T_OE_HIGH_NS = 30;

  // Least times round up to whole cycles; two extra cycles cover the input synchroniser.
  localparam int SYNC_CYC = 2;
  localparam logic [7:0] PD_LOW_CYC = 8'((T_PD_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WAKE_CYC = 8'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_HIGH_CYC = 8'((T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] READ_CYC = 8'((T_READ_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [7:0] OE_HIGH_CYC = 8'((T_OE_HIGH_NS + CLK_NS - 1) / CLK_NS);

  // Operations that the user side may request.
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_READ_ARRAY = 4'h1,
    OP_READ_ID = 4'h2,
    OP_READ_STATUS = 4'h3,
    OP_CLEAR_STATUS = 4'h4,
    OP_BLOCK_ERASE = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_WORD_WRITE = 4'h7,
    OP_SUSPEND = 4'h8,
    OP_RESUME = 4'h9,
    OP_SET_BLOCK_LOCK = 4'hA,
    OP_CLEAR_LOCKS = 4'hB,
    OP_SET_PERM_LOCK = 4'hC,
    OP_OTP_PROGRAM = 4'hD,
    OP_RESET = 4'hE
  } flc_op_e;

  // What read cycles return, as tracked by the host.
  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0,
    MODE_ID = 2'h1,
    MODE_STATUS = 2'h2
  } flc_mode_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    S_RESET = 3'h0,
    S_WAKE = 3'h1,
    S_IDLE = 3'h2,
    S_WR_LOW = 3'h3,
    S_WR_HIGH = 3'h4,
    S_RD_LOW = 3'h5,
    S_RD_HIGH = 3'h6
  } flc_state_e;

endpackage

// File: src/flc_sync.sv
// Two-stage synchroniser for the pins that the flash drives back to the host.
`timescale 1ns/1ps
module flc_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pin levels and their synchronised copies.
  input wire logic [flc_pkg::DATA_W:0] pin_in,
  output logic [flc_pkg::DATA_W:0] pin_sync
);

  logic [flc_pkg::DATA_W:0] stage1_r;
  logic [flc_pkg::DATA_W:0] stage2_r;

  // The first stage feeds only the second, so metastability cannot reach logic.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_r <= '1;
      stage2_r <= '1;
    end
    else
    begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
    end
  end

  assign pin_sync = stage2_r;

endmodule // flc_sync
